//--- rtl/prrs_remote_ctrl.v
// What this block does
// - Buffer write refused when writes disabled, unless CPU stopped
// - Remote run decoded, accepted all states
// - Remote stop decoded, accepted all states
// - Model code read accepted always
// - Model code and name read accepted
// - After run, state follows key switch
// - After stop to this CPU, CPU stopped unless CPU reset in same cycle
// - Remote stop holds against local computer
// - Both relays off: run, no clear
// - Unlatched relay only: clear unlatched data
// - All-clear relay on: clear everything
// - Power or reset discards remote state
// - CPU number F0H addresses whole network
// - CPU number 8n (n 1 to 9) addresses group n
// - Older bus network: dedicated number NAKs
// - Code two chars, name five padded
`timescale 1ns/1ps
`include "prrs_defines.vh"
module prrs_remote_ctrl (
  input wire clk,
  input wire rst_n,
  input wire cmdValid,
  input wire [7:0] cmdChar0,
  input wire [7:0] cmdChar1,
  input wire [7:0] cpuNumber,
  input wire [7:0] byteCount,
  input wire fromExternal,
  input wire [1:0] keySwitch,
  input wire writeEnabled,
  input wire cpuReset,
  input wire clear_all_memory_relay,
  input wire clear_unlatched_relay,
  input wire olderBusNetwork,
  input wire [7:0] modelCode,
  input wire [39:0] modelName,
  output reg ackPulse,
  output reg nakPulse,
  output reg [1:0] cpuState,
  output reg remoteStopped,
  output reg remoteStopExternal,
  output reg clearPulse,
  output reg [1:0] clearKind,
  output reg bufWritePulse,
  output reg [7:0] bufWriteCount,
  output reg netRunStopPulse,
  output reg netAll,
  output reg [3:0] netGroup,
  output reg netStop,
  output reg replyValid,
  output reg [15:0] replyCode,
  output reg [39:0] replyName,
  output reg replyHasName
);
  wire [2:0] cmdKind;
  reg remoteStopped_next;
  reg remoteStopExternal_next;
  reg ack_next;
  reg nak_next;
  reg clear_next;
  reg [1:0] clearKind_next;
  reg bufWrite_next;
  reg net_next;
  reg reply_next;
  reg hasName_next;
  reg isRunStop;
  reg dedicated;
  reg groupOk;

  prrs_cmd_decode uDecode (
    .cmdChar0(cmdChar0),
    .cmdChar1(cmdChar1),
    .cmdKind(cmdKind)
  );

  function [7:0] hexChar;
    input [3:0] nib;
    begin
      if (nib < 4'hA) begin
        hexChar = {4'h3, nib};
      end else begin
        hexChar = 8'h37 + {4'h0, nib};
      end
    end
  endfunction

  function [39:0] padName;
    input [39:0] name;
    integer k;
    begin
      padName = name;
      for (k = 0; k < 5; k = k + 1) begin
        if (name[k*8 +: 8] == 8'h00) begin
          padName[k*8 +: 8] = `PRRS_BLANK;
        end
      end
    end
  endfunction

  function isAllStations;
    input [7:0] num;
    begin
      isAllStations = (num == `PRRS_CPU_ALL);
    end
  endfunction

  function isGroupNumber;
    input [7:0] num;
    begin
      isGroupNumber = (num[7:4] == `PRRS_GROUP_HI) && (num[3:0] >= `PRRS_GROUP_MIN) &&
        (num[3:0] <= `PRRS_GROUP_MAX);
    end
  endfunction

  function [3:0] targetGroup;
    input [7:0] num;
    begin
      targetGroup = isAllStations(num) ? 4'h0 : num[3:0];
    end
  endfunction

  function writeAllowed;
    input [1:0] state;
    input enabled;
    begin
      writeAllowed = (state == `PRRS_ST_STOP) || enabled;
    end
  endfunction

  // Bad counts refused here so a faulty host cannot overrun buffer
  function countInRange;
    input [7:0] cnt;
    begin
      countInRange = (cnt >= `PRRS_BYTES_MIN) && (cnt <= `PRRS_BYTES_MAX);
    end
  endfunction

  function [1:0] relayClearKind;
    input allRelay;
    input unlatchedRelay;
    begin
      if (allRelay) begin
        relayClearKind = `PRRS_CLR_ALL;
      end else if (unlatchedRelay) begin
        relayClearKind = `PRRS_CLR_UNLATCHED;
      end else begin
        relayClearKind = `PRRS_CLR_NONE;
      end
    end
  endfunction

  function [15:0] hexPair;
    input [7:0] code;
    begin
      hexPair = {hexChar(code[7:4]), hexChar(code[3:0])};
    end
  endfunction

  function [1:0] resolveState;
    input stopped;
    input [1:0] key;
    begin
      resolveState = stopped ? `PRRS_ST_STOP : key;
    end
  endfunction

  always @* begin
    isRunStop = (cmdKind == `PRRS_K_RUN) || (cmdKind == `PRRS_K_STOP);
    dedicated = isAllStations(cpuNumber);
    groupOk = isGroupNumber(cpuNumber);
  end

  always @* begin
    remoteStopped_next = remoteStopped;
    remoteStopExternal_next = remoteStopExternal;
    ack_next = 1'b0;
    nak_next = 1'b0;
    clear_next = 1'b0;
    clearKind_next = clearKind;
    bufWrite_next = 1'b0;
    net_next = 1'b0;
    reply_next = 1'b0;
    hasName_next = replyHasName;
    if (cmdValid) begin
      if (isRunStop && (dedicated || groupOk)) begin
        if (olderBusNetwork) begin
          nak_next = 1'b1;
        end else begin
          net_next = 1'b1;
          ack_next = 1'b1;
        end
      end else if (cmdKind == `PRRS_K_WRITE) begin
        if (!writeAllowed(cpuState, writeEnabled)) begin
          nak_next = 1'b1;
        end else if (!countInRange(byteCount)) begin
          nak_next = 1'b1;
        end else begin
          bufWrite_next = 1'b1;
          ack_next = 1'b1;
        end
      end else if (cmdKind == `PRRS_K_RUN) begin
        if (remoteStopExternal && !fromExternal) begin
          nak_next = 1'b1;
        end else begin
          ack_next = 1'b1;
          remoteStopped_next = 1'b0;
          remoteStopExternal_next = 1'b0;
          if (remoteStopped) begin
            clear_next = 1'b1;
            clearKind_next = relayClearKind(clear_all_memory_relay, clear_unlatched_relay);
          end
        end
      end else if (cmdKind == `PRRS_K_STOP) begin
        ack_next = 1'b1;
        remoteStopped_next = 1'b1;
        remoteStopExternal_next = fromExternal;
      end else if (cmdKind == `PRRS_K_CODE || cmdKind == `PRRS_K_NAME) begin
        ack_next = 1'b1;
        reply_next = 1'b1;
        hasName_next = (cmdKind == `PRRS_K_NAME);
      end else begin
        nak_next = 1'b1;
      end
    end
    if (cpuReset) begin
      remoteStopped_next = 1'b0;
      remoteStopExternal_next = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackPulse <= 1'b0;
      nakPulse <= 1'b0;
      cpuState <= `PRRS_ST_STOP;
      remoteStopped <= 1'b0;
      remoteStopExternal <= 1'b0;
      clearPulse <= 1'b0;
      clearKind <= `PRRS_CLR_NONE;
    end else begin
      ackPulse <= ack_next;
      nakPulse <= nak_next;
      remoteStopped <= remoteStopped_next;
      remoteStopExternal <= remoteStopExternal_next;
      cpuState <= resolveState(remoteStopped_next, keySwitch);
      clearPulse <= clear_next;
      clearKind <= clearKind_next;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bufWritePulse <= 1'b0;
      bufWriteCount <= 8'h00;
      netRunStopPulse <= 1'b0;
      netAll <= 1'b0;
      netGroup <= 4'h0;
      netStop <= 1'b0;
    end else begin
      bufWritePulse <= bufWrite_next;
      if (bufWrite_next) begin
        bufWriteCount <= byteCount;
      end
      netRunStopPulse <= net_next;
      if (net_next) begin
        netAll <= dedicated;
        netGroup <= targetGroup(cpuNumber);
        netStop <= (cmdKind == `PRRS_K_STOP);
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      replyValid <= 1'b0;
      replyCode <= 16'h0000;
      replyName <= 40'h0000000000;
      replyHasName <= 1'b0;
    end else begin
      replyValid <= reply_next;
      replyHasName <= hasName_next;
      if (reply_next) begin
        replyCode <= hexPair(modelCode);
        replyName <= (cmdKind == `PRRS_K_NAME) ? padName(modelName) : {5{`PRRS_BLANK}};
      end
    end
  end
endmodule

//--- rtl/prrs_defines.vh
`ifndef PRRS_DEFINES_VH
`define PRRS_DEFINES_VH
// Command characters
`define PRRS_CH_T 8'h54
`define PRRS_CH_W 8'h57
`define PRRS_CH_R 8'h52
`define PRRS_CH_S 8'h53
`define PRRS_CH_P 8'h50
`define PRRS_CH_C 8'h43
`define PRRS_CH_U 8'h55
`define PRRS_BLANK 8'h20
// Buffer write byte count limits
`define PRRS_BYTES_MIN 8'h01
`define PRRS_BYTES_MAX 8'h80
// Dedicated CPU numbers
`define PRRS_CPU_ALL 8'hF0
`define PRRS_GROUP_HI 4'h8
`define PRRS_GROUP_MIN 4'h1
`define PRRS_GROUP_MAX 4'h9
// Key switch and CPU state codes
`define PRRS_ST_RUN 2'h0
`define PRRS_ST_STOP 2'h1
`define PRRS_ST_PAUSE 2'h2
`define PRRS_ST_STEP 2'h3
// Memory clear kinds
`define PRRS_CLR_NONE 2'h0
`define PRRS_CLR_UNLATCHED 2'h1
`define PRRS_CLR_ALL 2'h2
// Command kinds
`define PRRS_K_NONE 3'h0
`define PRRS_K_WRITE 3'h1
`define PRRS_K_RUN 3'h2
`define PRRS_K_STOP 3'h3
`define PRRS_K_CODE 3'h4
`define PRRS_K_NAME 3'h5
`endif

//--- rtl/prrs_cmd_decode.v
`timescale 1ns/1ps
`include "prrs_defines.vh"
module prrs_cmd_decode (
  input wire [7:0] cmdChar0,
  input wire [7:0] cmdChar1,
  output reg [2:0] cmdKind
);
  always @* begin
    cmdKind = `PRRS_K_NONE;
    if (cmdChar0 == `PRRS_CH_T && cmdChar1 == `PRRS_CH_W) begin
      cmdKind = `PRRS_K_WRITE;
    end else if (cmdChar0 == `PRRS_CH_R && cmdChar1 == `PRRS_CH_R) begin
      cmdKind = `PRRS_K_RUN;
    end else if (cmdChar0 == `PRRS_CH_R && cmdChar1 == `PRRS_CH_S) begin
      cmdKind = `PRRS_K_STOP;
    end else if (cmdChar0 == `PRRS_CH_P && cmdChar1 == `PRRS_CH_C) begin
      cmdKind = `PRRS_K_CODE;
    end else if (cmdChar0 == `PRRS_CH_P && cmdChar1 == `PRRS_CH_U) begin
      cmdKind = `PRRS_K_NAME;
    end
  end
endmodule

//--- bench/prrs_host.sv
`timescale 1ns/1ps
module prrs_host (
  input wire clk,
  output logic cmdValid,
  output logic [7:0] cmdChar0,
  output logic [7:0] cmdChar1,
  output logic [7:0] cpuNumber,
  output logic [7:0] byteCount,
  output logic fromExternal
);
  initial {cmdValid, cmdChar0, cmdChar1, cpuNumber, byteCount, fromExternal} = '0;
  // host count range
  // Bench passes bad counts only on purpose
  task send(input logic [15:0] code, input logic [7:0] num, input logic [7:0] cnt, input logic ext);
    @(posedge clk) #1;
    {cmdChar0, cmdChar1} = code;
    cpuNumber = num;
    byteCount = cnt;
    fromExternal = ext;
    cmdValid = 1'b1;
    @(posedge clk) #1;
    cmdValid = 1'b0;
    // Released lines show inverse, not stale code
    {cmdChar0, cmdChar1} = ~code;
  endtask
endmodule

//--- bench/prrs_chk.sv
`timescale 1ns/1ps
module prrs_chk (
  input wire clk, rst_n, cmdValid, fromExternal, cpuReset, clear_all_memory_relay, clear_unlatched_relay,
  input wire olderBusNetwork, clearPulse,
  input wire writeEnabled, remoteStopped, remoteStopExternal, ackPulse, nakPulse, bufWritePulse,
  input wire netRunStopPulse, netAll, replyValid, replyHasName,
  input wire [7:0] cmdChar0, cmdChar1, cpuNumber, byteCount, bufWriteCount,
  input wire [1:0] keySwitch, cpuState, clearKind
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = cmdValid && !cpuReset;
  wire [15:0] cc = {cmdChar0, cmdChar1};
  wire rs = go && (cc == 16'h5253 || cc == 16'h5252);
  wire loc = cpuNumber == 8'h00;
  wire tw = go && cc == 16'h5457;
  wire wOk = byteCount != 8'h00 && byteCount <= 8'h80 && (writeEnabled || cpuState == 2'h1);
  // Stop from outside, refused local run, then accepted outside run
  sequence s_ext_stop;
    rs && cc[0] && loc && fromExternal;
  endsequence
  sequence s_quiet;
    !cmdValid && !cpuReset;
  endsequence
  sequence s_local_run;
    rs && !cc[0] && loc && !fromExternal;
  endsequence
  sequence s_ext_run;
    rs && !cc[0] && loc && fromExternal;
  endsequence
  chk_stop_holds: assert property (s_ext_stop ##1 s_quiet ##1 s_local_run ##1 s_quiet ##1 s_ext_run
    |=> ackPulse && clearPulse) else $error("stop holds");
  chk_clear_kind: assert property (rs && !cc[0] && loc && fromExternal && remoteStopped |=> clearPulse
    && clearKind == ($past(clear_all_memory_relay) ? 2'h2 : {1'b0, $past(clear_unlatched_relay)}))
    else $error("clear kind");
  chk_one_answer: assert property (go |=> ackPulse != nakPulse) else $error("no single answer");
  chk_stop_enters: assert property (rs && cc[0] && loc |=> cpuState == 2'h1 && remoteStopped) else $error("stop");
  // First edge after release skipped: state still at reset value
  chk_state_follows: assert property ($past(rst_n) |-> cpuState == (remoteStopped ? 2'h1 : $past(keySwitch)))
    else $error("state");
  chk_local_run: assert property (rs && !cc[0] && loc && remoteStopExternal && !fromExternal |=> nakPulse
    && cpuState == 2'h1) else $error("local run");
  chk_write_bad: assert property (tw && !wOk |=> nakPulse && !bufWritePulse) else $error("write bad");
  chk_write_ok: assert property (tw && wOk |=> bufWritePulse && bufWriteCount == $past(byteCount))
    else $error("write ok");
  chk_older_nak: assert property (rs && olderBusNetwork && cpuNumber == 8'hF0 |=> nakPulse
    && !netRunStopPulse) else $error("older");
  chk_net_all: assert property (rs && !olderBusNetwork && cpuNumber == 8'hF0 |=> netRunStopPulse && netAll)
    else $error("net all");
  chk_reset_drop: assert property (cpuReset |=> !remoteStopped && !remoteStopExternal) else $error("drop");
  chk_clear_all: assert property (rs && !cc[0] && loc && fromExternal && remoteStopped && clear_all_memory_relay
    |=> clearKind == 2'h2) else $error("clear");
endmodule
bind prrs_remote_ctrl prrs_chk u_chk (.*);

//--- bench/prrs_remote_ctrl_bench.sv
`timescale 1ns/1ps
module prrs_remote_ctrl_bench;
  logic clk = 1'b0, rst_n = 1'b0, cpuReset = 1'b0, writeEnabled = 1'b0, olderBusNetwork = 1'b0;
  logic clear_all_memory_relay = 1'b0, clear_unlatched_relay = 1'b0;
  logic [1:0] keySwitch = 2'h0;
  logic [7:0] modelCode = 8'hA3;
  logic [39:0] modelName = 40'h0000434241;
  wire cmdValid, fromExternal, ackPulse, nakPulse, remoteStopped, remoteStopExternal, clearPulse;
  wire bufWritePulse, netRunStopPulse, netAll, netStop, replyValid, replyHasName;
  wire [1:0] cpuState, clearKind;
  wire [3:0] netGroup;
  wire [7:0] cmdChar0, cmdChar1, cpuNumber, byteCount, bufWriteCount;
  wire [15:0] replyCode;
  wire [39:0] replyName;
  int mismatches = 0, tests_run = 0;
  prrs_host host (.*);
  prrs_remote_ctrl dut (.*);
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_run_stop;
    for (int k = 0; k < 4; k++) begin
      keySwitch = k[1:0];
      {clear_all_memory_relay, clear_unlatched_relay} = k[1:0];
      host.send(16'h5253, 8'h00, 8'h01, 1'b1);
      chk({ackPulse, remoteStopped, cpuState}, 4'hD);
      host.send(16'h5252, 8'h00, 8'h01, 1'b0);
      chk({nakPulse, cpuState}, 3'h5);
      host.send(16'h5252, 8'h00, 8'h01, 1'b1);
      chk({ackPulse, clearPulse, cpuState, clearKind}, {2'h3, k[1:0], k[1] ? 2'h2 : {1'b0, k[0]}});
    end
    $display("test run_stop done");
  endtask
  task automatic t_write;
    logic [7:0] c;
    logic ok;
    for (int w = 0; w < 3; w++) begin
      keySwitch = (w == 2) ? 2'h1 : 2'h3;
      writeEnabled = (w == 1);
      for (int i = 0; i < 4; i++) begin
        c = (i < 2) ? i[7:0] : 8'h7E + i[7:0];
        ok = (w != 0) && (i == 1 || i == 2);
        host.send(16'h5457, 8'h00, c, 1'b1);
        chk({ackPulse, nakPulse, bufWritePulse, ok ? bufWriteCount : 8'h00}, {ok, !ok, ok, ok ? c : 8'h00});
      end
    end
    $display("test write done");
  endtask
  task automatic t_net;
    olderBusNetwork = 1'b1;
    host.send(16'h5253, 8'hF0, 8'h01, 1'b1);
    chk({nakPulse, netRunStopPulse}, 2'h2);
    host.send(16'h5252, 8'h81, 8'h01, 1'b1);
    chk({nakPulse, netRunStopPulse}, 2'h2);
    olderBusNetwork = 1'b0;
    host.send(16'h5253, 8'hF0, 8'h01, 1'b1);
    chk({ackPulse, netRunStopPulse, netAll, netStop, cpuState}, {4'hF, keySwitch});
    host.send(16'h5252, 8'h89, 8'h01, 1'b1);
    chk({ackPulse, netRunStopPulse, netAll, netGroup, netStop}, 8'hD2);
    $display("test net done");
  endtask
  task automatic t_reply;
    keySwitch = 2'h2;
    host.send(16'h5043, 8'h00, 8'h01, 1'b0);
    chk({ackPulse, replyValid, replyHasName, replyCode}, {3'h6, 16'h4133});
    host.send(16'h5055, 8'h00, 8'h01, 1'b1);
    chk({replyValid, replyHasName, replyName}, {2'h3, 40'h2020434241});
    host.send(16'h5A5A, 8'h00, 8'h01, 1'b1);
    chk({nakPulse, cpuState}, {1'b1, keySwitch});
    host.send(16'h5253, 8'h00, 8'h01, 1'b1);
    cpuReset = 1'b1;
    @(posedge clk) #1;
    cpuReset = 1'b0;
    chk({remoteStopped, remoteStopExternal, cpuState}, {2'h0, keySwitch});
    host.send(16'h5252, 8'h00, 8'h01, 1'b0);
    chk({ackPulse, clearPulse, cpuState}, {2'h2, keySwitch});
    $display("test reply done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_run_stop;
    t_write;
    t_net;
    t_reply;
    wrap_up;
  end
  initial begin
    #1000000;
    mismatches++;
    wrap_up;
  end
endmodule
